/* File: core/dsgm_monitor.sv */
/*
 * Drive sync group monitor: group assignment per port, spread check with
 * hysteresis, sticky summary flag, auto-abort of drive release and
 * synchronous forwarding of targets to all ports.
 * Assumes one process-data cycle is marked by a one-cycle pd_cycle pulse,
 * and that configuration writes arrive as single-cycle strobes.
 */
`timescale 1ns/1ps
`include "dsgm_consts.svh"

module dsgm_monitor
(
    input  wire logic                      core_clk,
    input  wire logic                      arst_n,
    input  wire logic                      pd_cycle,
    input  wire logic                      grp_wr,
    input  wire logic [3:0]                grp_wr_port,
    input  wire dsgm_pkg::dsgm_group_t     grp_wr_val,
    input  wire logic                      limit_wr,
    input  wire dsgm_pkg::dsgm_limit_t     limit_wr_val,
    input  wire logic                      ctl_wr,
    input  wire dsgm_pkg::dsgm_control_t   ctl_wr_val,
    input  wire logic [`DSGM_NUM_PORTS*`DSGM_POS_W-1:0] act_pos,
    input  wire logic [`DSGM_NUM_PORTS*`DSGM_POS_W-1:0] tgt_pos_in,
    input  wire logic [`DSGM_NUM_PORTS*16-1:0]          tgt_spd_in,
    input  wire dsgm_pkg::dsgm_port_vec_t  release_in,
    output logic [`DSGM_NUM_PORTS*`DSGM_POS_W-1:0]      tgt_pos_out,
    output logic [`DSGM_NUM_PORTS*16-1:0]               tgt_spd_out,
    output dsgm_pkg::dsgm_port_vec_t       release_out,
    output logic                           grp_wr_reject,
    output dsgm_pkg::dsgm_status_t         sync_status,
    output dsgm_pkg::dsgm_control_t        sync_control,
    output dsgm_pkg::dsgm_limit_t          sync_limit
);
    import dsgm_pkg::*;

    // Configuration and state registers.
    dsgm_group_t    grp_q [`DSGM_NUM_PORTS];
    dsgm_limit_t    limit_q;
    logic           abort_en_q;
    logic           clear_q;
    dsgm_grp_vec_t  flag_q;
    logic           summary_q;
    dsgm_state_t    state_q;
    dsgm_state_t    state_d;
    logic [`DSGM_NUM_PORTS*`DSGM_POS_W-1:0] tgt_pos_q;
    logic [`DSGM_NUM_PORTS*16-1:0]          tgt_spd_q;
    dsgm_port_vec_t release_q;
    logic           reject_q;

    // Membership test shared by the capacity check and the spread scan.
    // Keeping it in one place means both always agree on who belongs.
    function automatic logic is_member
    (
        input int          p,
        input dsgm_group_t g
    );
        return (grp_q[p] == g);
    endfunction : is_member

    // Member count of a group, excluding one port so a rewrite of the
    // same port does not count against itself.
    function automatic logic [3:0] count_members
    (
        input dsgm_group_t g,
        input logic [3:0]  skip
    );
        logic [3:0] n;
        n = 4'h0;
        for (int p = 0; p < `DSGM_NUM_PORTS; p++)
        begin
            if (is_member(p, g) && p[3:0] != skip)
            begin
                n = n + 4'h1;
            end
        end
        return n;
    endfunction : count_members

    // Group write legality: value in range, port exists, capacity left.
    wire [3:0] grp_fill = count_members(grp_wr_val, grp_wr_port);
    wire grp_val_ok  = (grp_wr_val <= 3'(`DSGM_NUM_GROUPS));
    wire grp_port_ok = (grp_wr_port < 4'(`DSGM_NUM_PORTS));
    wire grp_full    = (grp_wr_val != 3'h0) &&
                       (grp_fill >= 4'(`DSGM_GROUP_MAX));
    wire grp_accept  = grp_wr && grp_val_ok && grp_port_ok && !grp_full;

    // Spread per group from the latest positions. Signed positions are
    // compared; a group of fewer than two members gives zero spread.
    dsgm_pos_t      spread [`DSGM_NUM_GROUPS];
    logic           over   [`DSGM_NUM_GROUPS];
    logic           under  [`DSGM_NUM_GROUPS];
    always_comb
    begin
        for (int g = 0; g < `DSGM_NUM_GROUPS; g++)
        begin
            logic signed [`DSGM_POS_W-1:0] mx;
            logic signed [`DSGM_POS_W-1:0] mn;
            logic signed [`DSGM_POS_W-1:0] v;
            logic [3:0] cnt;
            mx  = '0;
            mn  = '0;
            v   = '0;
            cnt = 4'h0;
            for (int p = 0; p < `DSGM_NUM_PORTS; p++)
            begin
                v = act_pos[p*`DSGM_POS_W +: `DSGM_POS_W];
                if (is_member(p, 3'(g + 1)))
                begin
                    if (cnt == 4'h0 || v > mx)
                    begin
                        mx = v;
                    end
                    if (cnt == 4'h0 || v < mn)
                    begin
                        mn = v;
                    end
                    cnt = cnt + 4'h1;
                end
            end
            spread[g] = (cnt < 4'h2) ? '0 : dsgm_pos_t'(mx - mn);
            over[g]   = spread[g] > limit_q;
            under[g]  = spread[g] < (limit_q >> 1);
        end
    end

    // Next flag vector with hysteresis. A limit of 0 or 1 has a half of 0,
    // so a raised flag then stays up until a larger limit is written.
    dsgm_grp_vec_t flag_d;
    always_comb
    begin
        for (int g = 0; g < `DSGM_NUM_GROUPS; g++)
        begin
            flag_d[g] = over[g] ? 1'b1 : (under[g] ? 1'b0 : flag_q[g]);
        end
    end

    // Release gating: a port whose group is flagged with abort armed
    // loses its release for as long as the hold lasts.
    dsgm_port_vec_t hold;
    always_comb
    begin
        for (int p = 0; p < `DSGM_NUM_PORTS; p++)
        begin
            hold[p] = 1'b0;
            if (grp_q[p] != 3'h0 && abort_en_q)
            begin
                hold[p] = flag_q[grp_q[p] - 3'h1];
            end
        end
    end

    wire eval_now = (state_q == DSGM_EVAL);
    wire set_sum  = eval_now && |(flag_d & ~flag_q);

    // Sequencer: evaluation happens once after each cycle mark that arrives in DSGM_IDLE.
    // Evaluating one cycle late lets the drives' new positions settle on
    // act_pos first; a mark that falls in the evaluation cycle is ignored.
    always_comb
    begin
        case (state_q)
            DSGM_IDLE: state_d = pd_cycle ? DSGM_EVAL : DSGM_IDLE;
            DSGM_EVAL: state_d = DSGM_IDLE;
            default:   state_d = DSGM_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q <= DSGM_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Configuration registers; only defined control bits are stored.
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int p = 0; p < `DSGM_NUM_PORTS; p++)
            begin
                grp_q[p] <= 3'h0;
            end
            limit_q    <= `DSGM_LIMIT_RESET;
            abort_en_q <= 1'b0;
            clear_q    <= 1'b0;
            reject_q   <= 1'b0;
        end
        else
        begin
            if (grp_accept)
            begin
                grp_q[grp_wr_port] <= grp_wr_val;
            end
            reject_q <= grp_wr && !grp_accept;
            if (limit_wr)
            begin
                limit_q <= limit_wr_val;
            end
            if (ctl_wr)
            begin
                abort_en_q <= ctl_wr_val[`DSGM_CTL_ABORT_BIT];
                clear_q    <= ctl_wr_val[`DSGM_CTL_CLEAR_BIT];
            end
        end
    end

    // Flags and sticky summary. A new flag beats a pending clear, and the
    // clear only acts while no group is flagged.
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            flag_q    <= '0;
            summary_q <= 1'b0;
        end
        else
        begin
            if (eval_now)
            begin
                flag_q <= flag_d;
            end
            if (set_sum)
            begin
                summary_q <= 1'b1;
            end
            else if (clear_q && flag_q == '0)
            begin
                summary_q <= 1'b0;
            end
        end
    end

    // Targets for all ports are taken together at the cycle mark, so
    // the new commands reach every drive in the same cycle.
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tgt_pos_q <= '0;
            tgt_spd_q <= '0;
            release_q <= '0;
        end
        else
        begin
            if (pd_cycle)
            begin
                tgt_pos_q <= tgt_pos_in;
                tgt_spd_q <= tgt_spd_in;
            end
            release_q <= release_in & ~hold;
        end
    end

    // Register images are assembled from the field positions; every other
    // bit is tied to zero, so reserved bits always read as zero.
    dsgm_status_t  status_img;
    dsgm_control_t control_img;
    always_comb
    begin
        status_img                                         = '0;
        status_img[`DSGM_ST_SUMMARY_BIT]                   = summary_q;
        status_img[`DSGM_ST_GROUP_LSB +: `DSGM_NUM_GROUPS] = flag_q;
        control_img                                        = '0;
        control_img[`DSGM_CTL_ABORT_BIT]                   = abort_en_q;
        control_img[`DSGM_CTL_CLEAR_BIT]                   = clear_q;
    end

    // Outputs are plain copies of the registers above.
    assign tgt_pos_out   = tgt_pos_q;
    assign tgt_spd_out   = tgt_spd_q;
    assign release_out   = release_q;
    assign grp_wr_reject = reject_q;
    assign sync_status   = status_img;
    assign sync_control  = control_img;
    assign sync_limit    = limit_q;

endmodule : dsgm_monitor

/* File: core/dsgm_consts.svh */
/*
 * Constants for the drive sync group monitor: field positions, widths,
 * reset values and the group capacity.
 * Assumes it is included by the package and the monitor module by bare name.
 */
`ifndef DSGM_CONSTS_SVH
`define DSGM_CONSTS_SVH

`define DSGM_NUM_PORTS      10
`define DSGM_NUM_GROUPS     5
`define DSGM_GROUP_MAX      4
`define DSGM_POS_W          32
`define DSGM_LIMIT_W        32
`define DSGM_ST_SUMMARY_BIT 8
`define DSGM_ST_GROUP_LSB   9
`define DSGM_CTL_ABORT_BIT  0
`define DSGM_CTL_CLEAR_BIT  1
`define DSGM_LIMIT_RESET    32'h0000_0000
`define DSGM_STATUS_W       64
`define DSGM_CONTROL_W      32

`endif

/* File: core/dsgm_pkg.sv */
/*
 * Types shared by the drive sync group monitor.
 * Assumes dsgm_consts.svh is on the include path.
 */
`include "dsgm_consts.svh"

package dsgm_pkg;
    typedef logic [2:0]                   dsgm_group_t;
    typedef logic [`DSGM_POS_W-1:0]       dsgm_pos_t;
    typedef logic [`DSGM_LIMIT_W-1:0]     dsgm_limit_t;
    typedef logic [`DSGM_NUM_PORTS-1:0]   dsgm_port_vec_t;
    typedef logic [`DSGM_NUM_GROUPS-1:0]  dsgm_grp_vec_t;
    typedef logic [`DSGM_STATUS_W-1:0]    dsgm_status_t;
    typedef logic [`DSGM_CONTROL_W-1:0]   dsgm_control_t;

    typedef enum logic [1:0]
    {
        DSGM_IDLE = 2'b00,
        DSGM_EVAL = 2'b01
    } dsgm_state_t;
endpackage : dsgm_pkg

/* File: verification/dsgm_sva.sv */
/* Checker for the drive sync group monitor, bound to its ports.
   Assumes one clock domain with an asynchronous active-low reset. */
`timescale 1ns/1ps
`include "dsgm_consts.svh"
module dsgm_sva
(
    input wire logic                     core_clk,
    input wire logic                     arst_n,
    input wire logic                     pd_cycle,
    input wire logic                     grp_wr,
    input wire logic [3:0]               grp_wr_port,
    input wire dsgm_pkg::dsgm_group_t    grp_wr_val,
    input wire logic                     ctl_wr,
    input wire dsgm_pkg::dsgm_control_t  ctl_wr_val,
    input wire logic [319:0]             tgt_pos_in,
    input wire logic [319:0]             tgt_pos_out,
    input wire dsgm_pkg::dsgm_port_vec_t release_in,
    input wire dsgm_pkg::dsgm_port_vec_t release_out,
    input wire logic                     grp_wr_reject,
    input wire dsgm_pkg::dsgm_status_t   sync_status,
    input wire dsgm_pkg::dsgm_control_t  sync_control
);
    import dsgm_pkg::*;
    // All checks share one clock; reset silences them.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    wire any_flag = |sync_status[13:9];
    wire sum_bit  = sync_status[8];

    // Output relations to their causes, with exact latencies.
    fwd_same_a: assert property (pd_cycle |=> tgt_pos_out == $past(tgt_pos_in))
        else $error("targets not forwarded");
    rsvd_zero_a: assert property (sync_status[63:14] == '0 && sync_status[7:0] == '0)
        else $error("reserved status bit set");
    ctl_mask_a: assert property (ctl_wr |=>
        sync_control == {30'h0, $past(ctl_wr_val[1:0])})
        else $error("control write wrong");
    rej_bad_a: assert property (grp_wr &&
        (grp_wr_val > 3'h5 || grp_wr_port > 4'h9) |=> grp_wr_reject)
        else $error("bad group write taken");
    rej_cause_a: assert property (!grp_wr |=> !grp_wr_reject)
        else $error("reject without write");
    sum_flag_a: assert property (any_flag |-> sum_bit)
        else $error("flag without summary");
    sum_keep_a: assert property (sum_bit && !sync_control[1] |=> sum_bit)
        else $error("summary lost");
    sum_clr_a: assert property (sync_control[1] && !any_flag |=>
        !sum_bit || any_flag)
        else $error("summary not cleared");
    rel_pass_a: assert property (!sync_control[0] || !any_flag |=>
        release_out == $past(release_in))
        else $error("release gated wrongly");
    rel_mask_a: assert property (1'b1 |=> (release_out & ~$past(release_in)) == '0)
        else $error("release raised by monitor");
    flag_when_a: assert property ($changed(sync_status[13:9]) |-> $past(pd_cycle, 2))
        else $error("flag changed outside evaluation");
    flag_up_c: cover property ($rose(any_flag));
    hold_c: cover property (sync_control[0] && any_flag && release_out != release_in);
    reject_c: cover property (grp_wr_reject);
    sum_clr_c: cover property ($fell(sync_status[8]));
endmodule : dsgm_sva

bind dsgm_monitor dsgm_sva u_sva (.core_clk(core_clk), .arst_n(arst_n), .pd_cycle(pd_cycle),
    .grp_wr(grp_wr), .grp_wr_port(grp_wr_port), .grp_wr_val(grp_wr_val), .ctl_wr(ctl_wr),
    .ctl_wr_val(ctl_wr_val), .tgt_pos_in(tgt_pos_in), .tgt_pos_out(tgt_pos_out),
    .release_in(release_in), .release_out(release_out), .grp_wr_reject(grp_wr_reject),
    .sync_status(sync_status), .sync_control(sync_control));

/* File: verification/dsgm_drive_model.sv */
/* Behavioural model of ten positioning drives on the hub ports.
   Assumes targets and release come from the monitor outputs. */
`timescale 1ns/1ps
module dsgm_drive_model
#(
    parameter int STEP = 4
)
(
    input  wire logic                     core_clk,
    input  wire logic                     arst_n,
    input  wire logic                     pd_cycle,
    input  wire logic [319:0]             tgt_pos,
    input  wire dsgm_pkg::dsgm_port_vec_t rel,
    input  wire dsgm_pkg::dsgm_port_vec_t blocked,
    output logic [319:0]                  act_pos
);
    import dsgm_pkg::*;
    // A released drive steps once per data cycle; a jammed one keeps its place.
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            act_pos <= '0;
        else if (pd_cycle)
            for (int p = 0; p < 10; p++)
                if (rel[p] && !blocked[p])
                    act_pos[p*32+:32] <= act_pos[p*32+:32] +
                        (($signed(tgt_pos[p*32+:32]) > $signed(act_pos[p*32+:32])) ? STEP :
                         ($signed(tgt_pos[p*32+:32]) < $signed(act_pos[p*32+:32])) ? -STEP : 0);
    end
endmodule : dsgm_drive_model

/* File: verification/tb_top.sv */
/* Self-checking bench for the drive sync group monitor.
   Assumes the drive model moves one step of four per data cycle. */
`timescale 1ns/1ps
module tb_top;
    import dsgm_pkg::*;
    logic           core_clk = 1'b0, arst_n = 1'b0, pd_cycle = 1'b0;
    logic           grp_wr = 1'b0, limit_wr = 1'b0, ctl_wr = 1'b0, grp_wr_reject, r;
    logic [3:0]     grp_wr_port = 4'h0;
    dsgm_group_t    grp_wr_val = 3'h0;
    dsgm_limit_t    limit_wr_val = 32'h0, sync_limit;
    dsgm_control_t  ctl_wr_val = 32'h0, sync_control;
    dsgm_port_vec_t release_in = 10'h0, release_out, blocked = 10'h0;
    logic [319:0]   act_pos, tgt_pos_out, tgt_pos_in = '0;
    logic [159:0]   tgt_spd_out, tgt_spd_in = '0;
    dsgm_status_t   sync_status;
    logic [31:0]    pos;
    int             err_total = 0, cmp_count = 0, cyc = 0;

    // Free-running clock at 200 MHz.
    initial forever #2.5 core_clk = ~core_clk;

    dsgm_monitor dut (.core_clk(core_clk), .arst_n(arst_n), .pd_cycle(pd_cycle), .grp_wr(grp_wr),
        .grp_wr_port(grp_wr_port), .grp_wr_val(grp_wr_val), .limit_wr(limit_wr),
        .limit_wr_val(limit_wr_val), .ctl_wr(ctl_wr), .ctl_wr_val(ctl_wr_val), .act_pos(act_pos),
        .tgt_pos_in(tgt_pos_in), .tgt_spd_in(tgt_spd_in), .release_in(release_in),
        .tgt_pos_out(tgt_pos_out), .tgt_spd_out(tgt_spd_out), .release_out(release_out),
        .grp_wr_reject(grp_wr_reject), .sync_status(sync_status), .sync_control(sync_control),
        .sync_limit(sync_limit));
    dsgm_drive_model drv (.core_clk(core_clk), .arst_n(arst_n), .pd_cycle(pd_cycle),
        .tgt_pos(tgt_pos_out), .rel(release_out), .blocked(blocked), .act_pos(act_pos));

    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        cmp_count++;
        if (g !== e)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr_grp(input logic [3:0] p, input dsgm_group_t v);
        @(negedge core_clk) {grp_wr, grp_wr_port, grp_wr_val} = {1'b1, p, v};
        @(negedge core_clk) grp_wr = 1'b0;
        r = grp_wr_reject;
    endtask : wr_grp
    task automatic wr_ctl(input logic [1:0] v);
        @(negedge core_clk) {ctl_wr, ctl_wr_val} = {1'b1, 30'h3FFFFFFC, v};
        @(negedge core_clk) ctl_wr = 1'b0;
        chk("control", {62'h0, v}, sync_control);
        @(negedge core_clk);
    endtask : wr_ctl
    // Flags are settled one edge after the data cycle is taken.
    task automatic pd_step;
        @(negedge core_clk) pd_cycle = 1'b1;
        @(negedge core_clk) pd_cycle = 1'b0;
        repeat (2) @(negedge core_clk);
    endtask : pd_step
    function automatic int spread;
        int mx = $signed(act_pos[31:0]), mn = $signed(act_pos[31:0]);
        for (int p = 1; p < 4; p++)
        begin
            mx = ($signed(act_pos[p*32+:32]) > mx) ? $signed(act_pos[p*32+:32]) : mx;
            mn = ($signed(act_pos[p*32+:32]) < mn) ? $signed(act_pos[p*32+:32]) : mn;
        end
        return mx - mn;
    endfunction : spread

    // Ports 0 to 3 fill group 1; port 4 is alone in group 2.
    task automatic t_assign;
        chk("rst_status", 64'h0, sync_status);
        wr_ctl(2'h0);
        for (int p = 0; p < 4; p++)
        begin
            wr_grp(p[3:0], 3'h1);
            chk("join", 64'h0, r);
        end
        wr_grp(4'h4, 3'h1);
        chk("full", 64'h1, r);
        wr_grp(4'h3, 3'h1);
        chk("rejoin", 64'h0, r);
        wr_grp(4'h4, 3'h6);
        chk("range", 64'h1, r);
        wr_grp(4'hB, 3'h3);
        chk("port", 64'h1, r);
        wr_grp(4'h4, 3'h2);
        chk("join2", 64'h0, r);
        @(negedge core_clk) {limit_wr, limit_wr_val} = {1'b1, 32'h14};
        @(negedge core_clk) limit_wr = 1'b0;
        chk("limit", 64'h14, sync_limit);
    endtask : t_assign
    // A jammed port 0 must trip group 1 at a spread of 24 against 20.
    task automatic t_fault;
        wr_ctl(2'h1);
        {release_in, blocked, tgt_pos_in} = {10'h3FF, 10'h001, {10{32'h64}}};
        tgt_spd_in = {10{16'h0123}};
        for (int i = 0; i < 20 && sync_status[9] !== 1'b1; i++)
            pd_step();
        chk("status", 64'h300, sync_status);
        chk("lone", 64'h0, sync_status[10]);
        chk("spread", 64'd24, spread());
        chk("held", 10'h3F0, release_out);
        for (int p = 0; p < 10; p++)
        begin
            chk("tpos", 64'h64, tgt_pos_out[p*32+:32]);
            chk("tspd", 64'h0123, tgt_spd_out[p*16+:16]);
        end
        pos = act_pos[63:32];
        repeat (2) pd_step();
        chk("frozen", pos, act_pos[63:32]);
        chk("moving", 64'd32, act_pos[159:128]);
        wr_ctl(2'h3);
        chk("sticky", 64'h300, sync_status);
        wr_ctl(2'h0);
        chk("free", 10'h3FF, release_out);
    endtask : t_fault
    // The flag must stay until the spread drops under half the limit.
    task automatic t_recover;
        blocked = 10'h000;
        for (int i = 0; i < 60 && spread() >= 10; i++)
        begin
            chk("hyst", 64'h1, sync_status[9]);
            pd_step();
        end
        chk("cleared", 64'h100, sync_status);
        wr_ctl(2'h2);
        chk("reset", 64'h0, sync_status);
        wr_ctl(2'h1);
        chk("rearmed", 10'h3FF, release_out);
    endtask : t_recover

    task automatic final_report;
        $display("Errors %0d in %0d checks", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report
    // Cuts a hung run short.
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            err_total++;
            final_report();
        end
    end
    initial
    begin
        repeat (8) @(posedge core_clk);
        @(negedge core_clk) arst_n = 1'b1;
        t_assign();
        t_fault();
        t_recover();
        final_report();
    end
endmodule : tb_top
